// file: tsi_consts.svh
`ifndef TSI_CONSTS_SVH
`define TSI_CONSTS_SVH
// Notes on behaviour
// - Standard and fast rates only, no high-speed.
// - Device is slave only, never drives clock.
// - Seven address bits, then a direction bit.
// - Address is fixed pattern plus two straps.
// - Acknowledge own address only, ignore others.
// - Direction one reads, zero writes.
// - Register byte sent with top two bits zero.
// - Data bytes are eight bits, MSB first.
// - Device acknowledges own address and every byte received after it.
// - Write pointer increments, wraps to zero.
// - Master acknowledge fetches next register byte.
// - Read pointer wraps to zero past top.
// - Random read: dummy write, repeated start, read.
// - Master not-acknowledge then stop ends sending.
// - Master ends every transfer with a stop.
// - Data changes only while clock is low.
// - Low reset aborts any transfer at once.

// ==========================================================
// Addressing
`define TSI_ADDR_HI 5'h14
`define TSI_PTR_W 6
`define TSI_PTR_TOP 6'h3f

// ==========================================================
// Timing
`define TSI_REF_NS 25
`define TSI_SCL_NS 2500
`define TSI_QTR_CYC ((`TSI_SCL_NS / 4 + `TSI_REF_NS - 1) / `TSI_REF_NS)
`endif

// file: tsi_pkg.sv
`include "tsi_consts.svh"
package tsi_pkg;
  typedef enum logic [2:0] {
    D_IDLE = 3'h0, D_RX = 3'h1, D_ACK = 3'h2, D_TX = 3'h3, D_MACK = 3'h4
  } tsi_dst_t;
  typedef enum logic [1:0] {DP_SLAVE = 2'h0, DP_REG = 2'h1, DP_DATA = 2'h2} tsi_dph_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_START = 3'h1, H_BYTE = 3'h2, H_WAIT = 3'h3, H_STOP = 3'h4
  } tsi_hst_t;
  typedef enum logic [2:0] {
    HP_DEVW = 3'h0, HP_REG = 3'h1, HP_WDATA = 3'h2, HP_DEVR = 3'h3, HP_RDATA = 3'h4
  } tsi_hph_t;
  typedef struct packed {
    tsi_dst_t st;
    tsi_dph_t ph;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [`TSI_PTR_W-1:0] ptr;
    logic [7:0] tx;
    logic sda_oe;
    logic req;
    logic we;
    logic [`TSI_PTR_W-1:0] baddr;
    logic [7:0] bdata;
    logic ack_seen;
    logic [7:0] rdata;
  } tsi_dlink_t;
  typedef struct packed {
    logic seen;
    logic ack;
    logic wr;
    logic rd;
    logic [`TSI_PTR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } tsi_dref_t;
  typedef struct packed {
    tsi_hst_t st;
    tsi_hph_t ph;
    logic [1:0] q;
    logic [15:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] len;
    logic rnw;
    logic [6:0] dev;
    logic [`TSI_PTR_W-1:0] rg;
    logic scl_oe;
    logic sda_oe;
    logic nack;
    logic [7:0] rdata;
    logic rvalid;
    logic done;
  } tsi_host_t;
endpackage

// file: tsi_if.sv
interface tsi_if;
  logic scl_o;
  logic scl_oe;
  logic hsda_o;
  logic hsda_oe;
  logic dsda_o;
  logic dsda_oe;
  logic scl;
  logic sda;

  // Both lines are open drain with pull-ups, so the wire is a wired AND.
  assign scl = !(scl_oe && !scl_o);
  assign sda = !(hsda_oe && !hsda_o) && !(dsda_oe && !dsda_o);

  modport host (output scl_o, output scl_oe, output hsda_o, output hsda_oe,
    input scl, input sda);
  modport dev (output dsda_o, output dsda_oe, input scl, input sda);
endinterface

// file: tsi_sync.sv
module tsi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tsi_sync_t;

  tsi_sync_t r;
  tsi_sync_t next_r;

  if (W < 1)
  begin : g_bad_w
    $error("tsi_sync width must be at least one.");
  end

  // Two stages; only the second stage is visible to the caller.
  always_comb
  begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      r <= {INIT, INIT};
    else
      r <= next_r;
  end

  assign q = r.s2;
endmodule

// file: tsi_host.sv
`include "tsi_consts.svh"
module tsi_host #(
  parameter int QTR_CYC = `TSI_QTR_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bus pins
  tsi_if.host bus,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [6:0] cmd_dev,
  input wire logic cmd_rnw,
  input wire logic [`TSI_PTR_W-1:0] cmd_reg,
  input wire logic [7:0] cmd_len,
  // Write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [7:0] wdata,
  // Read data and status
  output logic rvalid,
  output logic [7:0] rdata,
  output logic done,
  output logic nack
);
  tsi_pkg::tsi_host_t r;
  tsi_pkg::tsi_host_t n;
  logic sda_s;
  logic tick;
  logic tx;

  if (QTR_CYC < 2 || QTR_CYC > 65535)
  begin : g_bad_qtr
    $error("tsi_host quarter count out of range.");
  end

  tsi_sync #(.W(1), .INIT(1'h1)) u_sda_sync (
    .clk(ref_clk),
    .resetn(resetn),
    .d(bus.sda),
    .q(sda_s)
  );

  assign tick = r.div == 16'(QTR_CYC - 1);
  assign tx = r.ph != tsi_pkg::HP_RDATA;

  // ========================================================
  // Sequencer: each bit is four quarters; SDA moves only in quarter 0
  // with SCL low, except inside start and stop.
  always_comb
  begin
    n = r;
    n.rvalid = 1'b0;
    n.done = 1'b0;
    n.div = tick ? 16'h0000 : r.div + 16'h0001;
    if (tick)
      n.q = r.q + 2'h1;
    case (r.st)
      tsi_pkg::H_IDLE:
      begin
        n.div = 16'h0000;
        n.q = 2'h0;
        if (cmd_valid)
        begin
          n.dev = cmd_dev;
          n.rnw = cmd_rnw;
          n.rg = cmd_reg;
          n.len = cmd_len;
          n.nack = 1'b0;
          n.ph = tsi_pkg::HP_DEVW;
          n.st = tsi_pkg::H_START;
        end
      end
      tsi_pkg::H_START:
        if (tick)
          case (r.q)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            default:
            begin
              n.scl_oe = 1'b1;
              n.sh = {r.dev, r.ph == tsi_pkg::HP_DEVR};
              n.bitn = 4'h0;
              n.st = tsi_pkg::H_BYTE;
            end
          endcase
      tsi_pkg::H_WAIT:
      begin
        // SCL is held low while the user has no byte ready.
        n.div = 16'h0000;
        n.q = 2'h0;
        if (wvalid)
        begin
          n.sh = wdata;
          n.bitn = 4'h0;
          n.ph = tsi_pkg::HP_WDATA;
          n.st = tsi_pkg::H_BYTE;
        end
      end
      tsi_pkg::H_BYTE:
        if (tick)
          case (r.q)
            2'h0:
              if (r.bitn != 4'h8)
                n.sda_oe = tx && !r.sh[7];
              else
                n.sda_oe = !tx && r.len != 8'h01;
            2'h1: n.scl_oe = 1'b0;
            2'h2:
              if (r.bitn != 4'h8)
                n.sh = {r.sh[6:0], sda_s};
              else if (tx && sda_s)
                n.nack = 1'b1;
            default:
            begin
              n.scl_oe = 1'b1;
              n.bitn = r.bitn + 4'h1;
              if (r.bitn == 4'h8)
              begin
                n.bitn = 4'h0;
                if (tx && r.nack)
                  n.st = tsi_pkg::H_STOP;
                else
                  case (r.ph)
                    tsi_pkg::HP_DEVW:
                    begin
                      n.ph = tsi_pkg::HP_REG;
                      n.sh = {2'b00, r.rg};
                    end
                    tsi_pkg::HP_REG:
                      if (r.rnw)
                      begin
                        n.ph = tsi_pkg::HP_DEVR;
                        n.st = tsi_pkg::H_START;
                      end
                      else
                        n.st = tsi_pkg::H_WAIT;
                    tsi_pkg::HP_DEVR: n.ph = tsi_pkg::HP_RDATA;
                    default:
                    begin
                      n.len = r.len - 8'h01;
                      n.rdata = tx ? r.rdata : r.sh;
                      n.rvalid = !tx;
                      if (r.len == 8'h01)
                        n.st = tsi_pkg::H_STOP;
                      else if (tx)
                        n.st = tsi_pkg::H_WAIT;
                    end
                  endcase
              end
            end
          endcase
      tsi_pkg::H_STOP:
        if (tick)
          case (r.q)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            default:
            begin
              n.done = 1'b1;
              n.st = tsi_pkg::H_IDLE;
            end
          endcase
      default: n.st = tsi_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      r <= '0;
    else
      r <= n;
  end

  assign cmd_ready = r.st == tsi_pkg::H_IDLE;
  assign wready = r.st == tsi_pkg::H_WAIT;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign done = r.done;
  assign nack = r.nack;
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = r.scl_oe;
  assign bus.hsda_o = 1'b0;
  assign bus.hsda_oe = r.sda_oe;
endmodule

// file: tsi_device.sv
`include "tsi_consts.svh"
module tsi_device (
  // Clocks and reset
  input wire logic link_clk,
  input wire logic ref_clk,
  input wire logic resetn,
  // Bus pins
  tsi_if.dev bus,
  // Address straps
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit0,
  // Register file port, ref_clk domain
  output logic reg_wr,
  output logic reg_rd,
  output logic [`TSI_PTR_W-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // ========================================================
  // Link and ref_clk domain declarations
  tsi_pkg::tsi_dlink_t lk;
  tsi_pkg::tsi_dlink_t next_lk;
  tsi_pkg::tsi_dref_t rf;
  tsi_pkg::tsi_dref_t next_rf;
  logic [4:0] ls;
  logic scl_s;
  logic sda_s;
  logic ack_s;
  logic req_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [6:0] own;

  // Pointer advance shared by writes and reads.
  function automatic logic [`TSI_PTR_W-1:0] ptr_next(input logic [`TSI_PTR_W-1:0] p);
    ptr_next = (p == `TSI_PTR_TOP) ? '0 : p + 1'b1;
  endfunction

  // Launch one register access across to the ref_clk side.
  function automatic tsi_pkg::tsi_dlink_t issue(input tsi_pkg::tsi_dlink_t s,
    input logic we, input logic [`TSI_PTR_W-1:0] a, input logic [7:0] d);
    tsi_pkg::tsi_dlink_t o;
    o = s;
    o.req = !s.req;
    o.we = we;
    o.baddr = a;
    o.bdata = d;
    issue = o;
  endfunction

  // Start a byte out of the prefetched data and fetch the next one.
  function automatic tsi_pkg::tsi_dlink_t load_tx(input tsi_pkg::tsi_dlink_t s);
    tsi_pkg::tsi_dlink_t o;
    o = s;
    o.tx = s.rdata;
    o.sda_oe = !s.rdata[7];
    o.cnt = 4'h0;
    o.st = tsi_pkg::D_TX;
    o.ptr = ptr_next(s.ptr);
    load_tx = issue(o, 1'b0, ptr_next(s.ptr), 8'h00);
  endfunction

  // Pins, straps and the answer toggle all come from other domains.
  tsi_sync #(.W(5), .INIT(5'h18)) u_link_sync (
    .clk(link_clk),
    .resetn(resetn),
    .d({bus.scl, bus.sda, addr_strap_bit1, addr_strap_bit0, rf.ack}),
    .q(ls)
  );

  tsi_sync #(.W(1), .INIT(1'h0)) u_ref_sync (
    .clk(ref_clk),
    .resetn(resetn),
    .d(lk.req),
    .q(req_s)
  );

  // Bus events from the synchronised lines and their previous samples.
  assign scl_s = ls[4];
  assign sda_s = ls[3];
  assign ack_s = ls[0];
  assign own = {`TSI_ADDR_HI, ls[2], ls[1]};
  assign rise = scl_s && !lk.scl_q;
  assign fall = !scl_s && lk.scl_q;
  assign start = scl_s && lk.scl_q && lk.sda_q && !sda_s;
  assign stop = scl_s && lk.scl_q && !lk.sda_q && sda_s;

  // ========================================================
  // Serial engine. It only samples and answers the clock it is given;
  // the two-stage sampling limits it to bus rates far below link_clk.
  always_comb
  begin
    next_lk = lk;
    next_lk.scl_q = scl_s;
    next_lk.sda_q = sda_s;
    // Fetched data is stable by the time its toggle is seen here.
    if (ack_s != lk.ack_seen)
    begin
      next_lk.ack_seen = ack_s;
      next_lk.rdata = rf.rdata;
    end
    if (start)
    begin
      // A repeated start looks the same and leaves the pointer alone.
      next_lk.st = tsi_pkg::D_RX;
      next_lk.ph = tsi_pkg::DP_SLAVE;
      next_lk.cnt = 4'h0;
      next_lk.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      next_lk.st = tsi_pkg::D_IDLE;
      next_lk.sda_oe = 1'b0;
    end
    else
      case (lk.st)
        tsi_pkg::D_RX:
          if (rise)
          begin
            next_lk.sh = {lk.sh[6:0], sda_s};
            next_lk.cnt = lk.cnt + 4'h1;
          end
          else if (fall && lk.cnt == 4'h8)
          begin
            next_lk.cnt = 4'h0;
            next_lk.st = tsi_pkg::D_ACK;
            next_lk.sda_oe = 1'b1;
            case (lk.ph)
              tsi_pkg::DP_SLAVE:
                if (lk.sh[7:1] == own)
                begin
                  next_lk.rw = lk.sh[0];
                  if (lk.sh[0])
                    next_lk = issue(next_lk, 1'b0, lk.ptr, 8'h00);
                end
                else
                begin
                  next_lk.st = tsi_pkg::D_IDLE;
                  next_lk.sda_oe = 1'b0;
                end
              tsi_pkg::DP_REG: next_lk.ptr = lk.sh[`TSI_PTR_W-1:0];
              default:
              begin
                next_lk = issue(next_lk, 1'b1, lk.ptr, lk.sh);
                next_lk.ptr = ptr_next(lk.ptr);
              end
            endcase
          end
        tsi_pkg::D_ACK:
          if (fall)
          begin
            next_lk.sda_oe = 1'b0;
            next_lk.st = tsi_pkg::D_RX;
            case (lk.ph)
              tsi_pkg::DP_SLAVE:
                if (lk.rw)
                  next_lk = load_tx(next_lk);
                else
                  next_lk.ph = tsi_pkg::DP_REG;
              tsi_pkg::DP_REG: next_lk.ph = tsi_pkg::DP_DATA;
              default: next_lk.ph = tsi_pkg::DP_DATA;
            endcase
          end
        tsi_pkg::D_TX:
          // The line only moves after SCL has been seen low.
          if (fall)
          begin
            if (lk.cnt == 4'h7)
            begin
              next_lk.sda_oe = 1'b0;
              next_lk.st = tsi_pkg::D_MACK;
            end
            else
            begin
              next_lk.tx = {lk.tx[6:0], 1'b0};
              next_lk.sda_oe = !lk.tx[6];
              next_lk.cnt = lk.cnt + 4'h1;
            end
          end
        tsi_pkg::D_MACK:
          if (rise && sda_s)
            next_lk.st = tsi_pkg::D_IDLE;
          else if (fall)
            next_lk = load_tx(next_lk);
        default: next_lk.sda_oe = 1'b0;
      endcase
  end

  // Reset clears the engine at once, wherever a transfer stood.
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lk <= '0;
      lk.scl_q <= 1'b1;
      lk.sda_q <= 1'b1;
    end
    else
      lk <= next_lk;
  end

  // ========================================================
  // Register port side. A request toggle carries a stable bundle;
  // the answer toggle returns once the access has been made.
  always_comb
  begin
    next_rf = rf;
    next_rf.wr = 1'b0;
    next_rf.rd = 1'b0;
    if (rf.rd)
    begin
      next_rf.rdata = reg_rdata;
      next_rf.ack = !rf.ack;
    end
    if (rf.wr)
      next_rf.ack = !rf.ack;
    if (req_s != rf.seen)
    begin
      next_rf.seen = req_s;
      next_rf.wr = lk.we;
      next_rf.rd = !lk.we;
      next_rf.addr = lk.baddr;
      next_rf.wdata = lk.bdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rf <= '0;
    else
      rf <= next_rf;
  end

  // The device never drives SCL and only ever pulls SDA low.
  assign bus.dsda_o = 1'b0;
  assign bus.dsda_oe = lk.sda_oe;
  assign reg_wr = rf.wr;
  assign reg_rd = rf.rd;
  assign reg_addr = rf.addr;
  assign reg_wdata = rf.wdata;
endmodule

// file: tsi_link_checker.sv
module tsi_link_checker (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic resetn,
  // Open-drain drives of both ends
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic hsda_o,
  input wire logic hsda_oe,
  input wire logic dsda_o,
  input wire logic dsda_oe,
  // Resolved wire levels
  input wire logic scl,
  input wire logic sda
);
  // ==========================================================
  // Sampling
  // All checks sample on the link clock, the domain the device lives in.
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Wire checks
  // Only the host pulls the clock, and no end ever drives a line high.
  clk_host_only_a: assert property (scl == !scl_oe && !scl_o && !hsda_o && !dsda_o)
    else $error("clock line driven by other than the host");
  // The device moves its data drive only while the clock is low.
  dev_sda_stable_a: assert property (scl && $past(scl) |-> $stable(dsda_oe))
    else $error("device changed data while clock high");
  host_release_a: assert property (dsda_oe && scl |-> !hsda_oe)
    else $error("host drove data while device was sending");
  dev_drive_low_a: assert property ($rose(dsda_oe) |-> !scl [*2])
    else $error("device drive started outside clock low");
  // A low phase shorter than eight link cycles would mean a faster bus mode.
  scl_low_width_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  start_clk_a: assert property ($fell(sda) && scl && $past(scl) |-> ##[1:12] !scl)
    else $error("start not followed by clock low");
  stop_release_a: assert property ($rose(sda) && scl && $past(scl) |=> !dsda_oe [*8])
    else $error("device drove data after stop");
  // Reset must hold both lines released, so this check runs during reset too.
  reset_quiet_a: assert property (disable iff (1'b0)
    !resetn |-> !scl_oe && !hsda_oe && !dsda_oe)
    else $error("line driven during reset");
endmodule

// file: touch_sensor_i2c_register_port_tb_top.sv
`include "tsi_consts.svh"
module touch_sensor_i2c_register_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Small quarter keeps the run short; still above six link periods.
  localparam int QTR = 8;
  // ==========================================================
  // Signals and model state
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  // Reset starts high so that its fall is a real edge for every process.
  logic resetn = 1'b1;
  logic addr_strap_bit1 = 1'b0;
  logic addr_strap_bit0 = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_rnw = 1'b0;
  logic wvalid = 1'b0;
  logic [6:0] cmd_dev = 7'h00;
  logic [5:0] cmd_reg = 6'h00;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic cmd_ready, wready, rvalid, done, nack, reg_wr, reg_rd;
  logic [7:0] rdata, reg_wdata, reg_rdata;
  logic [5:0] reg_addr;
  logic [7:0] regs [64];
  logic [7:0] em [64];
  logic [7:0] wq [$];
  logic [31:0] seed = 32'h00000060;
  int err_count = 0;
  int compares = 0;
  int rd_count = 0;
  tsi_if bus_if();
  // ==========================================================
  // Design ends, checker and register file
  tsi_host #(.QTR_CYC(QTR)) u_tsi_host (.ref_clk(ref_clk), .resetn(resetn), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_dev(cmd_dev), .cmd_rnw(cmd_rnw),
    .cmd_reg(cmd_reg), .cmd_len(cmd_len), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .rvalid(rvalid), .rdata(rdata), .done(done), .nack(nack));
  tsi_device u_tsi_device (.link_clk(link_clk), .ref_clk(ref_clk), .resetn(resetn),
    .bus(bus_if), .addr_strap_bit1(addr_strap_bit1), .addr_strap_bit0(addr_strap_bit0),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  tsi_link_checker u_tsi_link_checker (.link_clk(link_clk), .resetn(resetn),
    .scl_o(bus_if.scl_o), .scl_oe(bus_if.scl_oe), .hsda_o(bus_if.hsda_o),
    .hsda_oe(bus_if.hsda_oe), .dsda_o(bus_if.dsda_o), .dsda_oe(bus_if.dsda_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));
  // Register file answers reads at once, as the device port expects.
  assign reg_rdata = regs[reg_addr];
  always @(posedge ref_clk)
    if (reg_wr === 1'b1) regs[reg_addr] <= reg_wdata;
  // Read strobes reaching the register file, counted per transfer.
  always @(posedge ref_clk)
    if (reg_rd === 1'b1) rd_count++;
  // ==========================================================
  // Clocks; the link clock is offset so its edges never line up with ours.
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #4;
    forever #15 link_clk = ~link_clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic fill(input int n);
    wq = {};
    repeat (n)
    begin
      seed = xs(seed);
      wq.push_back(seed[7:0]);
    end
  endtask
  // One host command; the model is updated only when the device should accept.
  task automatic xfer(input logic [6:0] dev, input logic rnw, input logic [5:0] rg,
    input int n, input logic enack);
    int k;
    int t;
    logic fin;
    logic [7:0] rq [$];
    k = 0;
    fin = 1'b0;
    @(posedge ref_clk);
    #1;
    rd_count = 0;
    cmd_valid = 1'b1;
    cmd_dev = dev;
    cmd_rnw = rnw;
    cmd_reg = rg;
    cmd_len = n[7:0];
    t = 0;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1 && ++t < 100);
    #1;
    cmd_valid = 1'b0;
    for (t = 0; t < 20000 && !fin; t++)
    begin
      wvalid = !rnw && k < n;
      wdata = (k < wq.size()) ? wq[k] : 8'h00;
      @(posedge ref_clk);
      if (wvalid && wready === 1'b1) k++;
      if (rvalid === 1'b1) rq.push_back(rdata);
      fin = (done === 1'b1);
      #1;
    end
    wvalid = 1'b0;
    chk({7'h00, fin}, 8'h01, "transfer completion");
    chk({7'h00, nack}, {7'h00, enack}, "device acknowledge");
    if (rnw && !enack)
    begin
      chk(8'(rq.size()), 8'(n), "read byte count");
      // One fetch at the address, then one ahead of every byte sent.
      chk(8'(rd_count), 8'(n + 1), "register read strobes");
      foreach (rq[i]) chk(rq[i], em[(rg + i) % 64], "read data");
    end
    if (!rnw && !enack)
      for (int i = 0; i < n; i++) em[(rg + i) % 64] = wq[i];
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Watchdog; the tests need well under half this span.
  initial
  begin
    #2000000;
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    results();
  end
  // ==========================================================
  // Test sequence
  initial
  begin
    logic [6:0] own;
    logic [5:0] rg;
    for (int i = 0; i < 64; i++)
    begin
      regs[i] = 8'h00;
      em[i] = 8'h00;
    end
    #1;
    resetn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    // Every strap setting; odd passes spoil the fixed part instead of the straps.
    for (int s = 0; s < 4; s++)
    begin
      @(posedge ref_clk);
      #1;
      {addr_strap_bit1, addr_strap_bit0} = s[1:0];
      own = {`TSI_ADDR_HI, s[1:0]};
      repeat (8) @(posedge ref_clk);
      fill(2);
      rg = seed[13:8];
      xfer(own, 1'b0, rg, 2, 1'b0);
      fill(1);
      xfer(s[0] ? (own ^ 7'h40) : (own ^ 7'h03), 1'b0, rg, 1, 1'b1);
      xfer(own, 1'b1, rg, 2, 1'b0);
    end
    $display("test straps done");
    // Burst across the top of the pointer, then read back across it.
    fill(5);
    xfer(own, 1'b0, 6'h3e, 5, 1'b0);
    xfer(own, 1'b1, 6'h3d, 6, 1'b0);
    xfer(own, 1'b1, 6'h3f, 1, 1'b0);
    $display("test wrap done");
    // Reset in the middle of the register byte aborts the transfer.
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_rnw = 1'b0;
    cmd_reg = 6'h10;
    cmd_len = 8'h01;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    repeat (350) @(posedge ref_clk);
    #1;
    resetn = 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({6'h00, bus_if.scl, bus_if.sda}, 8'h03, "lines after reset");
    chk({7'h00, cmd_ready}, 8'h01, "host idle after reset");
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge ref_clk);
    xfer(own, 1'b1, 6'h3e, 4, 1'b0);
    for (int i = 0; i < 64; i++) chk(regs[i], em[i], "register contents");
    $display("test reset done");
    results();
  end
endmodule
